// file: acd_player.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module acd_player #(
  parameter int n_chan = 4
) (
  input  wire logic        pclk,            // System clock, 100 MHz.
  input  wire logic        presetn,         // Asynchronous reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB access phase.
  input  wire logic        pwrite,          // APB direction, high for write.
  input  wire logic [7:0]  paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic      [31:0] prdata,          // APB read data.
  output logic             pready,          // APB ready.
  output logic             pslverr,         // APB error, unmapped address.
  output logic             mem_req,         // Memory fetch request.
  output logic      [17:0] mem_addr,        // Word address of the fetch.
  output logic      [1:0]  mem_chan,        // Channel owning the fetch.
  input  wire logic        mem_ack,         // Fetch data is valid.
  input  wire logic [15:0] mem_rdata,       // Fetched data word.
  input  wire logic        slot_strobe,     // Start of a DMA slot group, a pin.
  output logic      [3:0]  chan_irq,        // Pulse after working copies taken.
  output logic      [31:0] dac_sample,      // Four 8-bit samples, ch3 on top.
  output logic      [27:0] dac_volume,      // Four 7-bit volumes, ch3 on top.
  output logic      [3:0]  dac_active       // Channel is producing sound.
);
  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [15:0] dma_control_set_clear;
  logic [7:0]  attach_control;
  logic [2:0]  start_addr_high [n_chan];
  logic [14:0] start_addr_low  [n_chan];
  logic [15:0] wave_word_count [n_chan];
  logic [15:0] sample_period   [n_chan];
  logic [6:0]  channel_volume  [n_chan];
  logic        wr_en;
  logic        addr_ok;
  logic [1:0]  reg_chan;
  logic [31:0] next_rdata;

  assign wr_en    = psel && penable && pwrite;
  assign reg_chan = 2'(paddr[5:4] - acd_pkg::off_chan_base[5:4]);
  // The word between the status register and the first channel is a hole.
  // Flagging it keeps software from mistaking it for a silent register.
  assign addr_ok  = (paddr[1:0] == 2'h0) &&
                    !(paddr > acd_pkg::off_status && paddr < acd_pkg::off_chan_base) &&
                    (paddr < (acd_pkg::off_chan_base + 8'(n_chan * 16)));

  // DMA control bits are updated by set or clear, never by plain store.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_control_set_clear <= acd_pkg::dma_control_reset;
    end else if (wr_en && paddr == acd_pkg::off_dma_control) begin
      if (pwdata[acd_pkg::bit_set_or_clear]) begin
        dma_control_set_clear <= dma_control_set_clear | (pwdata[15:0] & 16'h7fff);
      end else begin
        dma_control_set_clear <= dma_control_set_clear & ~(pwdata[15:0] & 16'h7fff);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attach_control <= acd_pkg::attach_reset;
    end else if (wr_en && paddr == acd_pkg::off_attach_control) begin
      attach_control <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel state
  // ----------------------------------------------------------------------
  logic [17:0] work_ptr    [n_chan];
  logic [15:0] work_len    [n_chan];
  logic [15:0] period_cnt  [n_chan];
  logic [15:0] data_word   [n_chan];
  logic        word_valid  [n_chan];
  logic        low_half    [n_chan];
  logic        running     [n_chan];
  logic        mod_is_per  [n_chan];
  logic [15:0] off_cnt     [n_chan];
  logic [3:0]  fetch_pend;
  logic [3:0]  chan_on;
  logic [3:0]  attached;
  logic [3:0]  expire;
  logic [3:0]  mod_wr_vol;
  logic [3:0]  mod_wr_per;
  logic [1:0]  slot_idx;
  logic        slot_s1;
  logic        slot_s2;
  logic        slot_s3;
  logic        busy;

  function automatic logic [17:0] loc_of(input logic [2:0] hi, input logic [14:0] lo);
    return {hi, lo};
  endfunction : loc_of

  always_comb begin
    for (int c = 0; c < n_chan; c++) begin
      chan_on[c]  = dma_control_set_clear[acd_pkg::bit_master_enable] &&
                    dma_control_set_clear[c];
      attached[c] = attach_control[c] ||
                    attach_control[c + acd_pkg::pos_period_attach];
      expire[c]   = running[c] && (period_cnt[c] == 16'h0000) && word_valid[c];
    end
  end

  // A modulator's expiry drives the next channel; channel 3 has no target.
  always_comb begin
    mod_wr_vol = 4'h0;
    mod_wr_per = 4'h0;
    for (int c = 0; c < n_chan - 1; c++) begin
      if (expire[c] && attached[c]) begin
        if (attach_control[c] && attach_control[c + acd_pkg::pos_period_attach]) begin
          mod_wr_vol[c + 1] = !mod_is_per[c];
          mod_wr_per[c + 1] = mod_is_per[c];
        end else begin
          mod_wr_vol[c + 1] = attach_control[c];
          mod_wr_per[c + 1] = attach_control[c + acd_pkg::pos_period_attach];
        end
      end
    end
  end

  // Channel registers; a modulator write lands in the modulated channel.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < n_chan; c++) begin
        start_addr_high[c] <= 3'h0;
        start_addr_low[c]  <= 15'h0000;
        wave_word_count[c] <= 16'h0000;
        sample_period[c]   <= acd_pkg::period_reset;
        channel_volume[c]  <= acd_pkg::volume_reset;
      end
    end else begin
      // Channel 0 has no modulator below it, so the loop starts at channel 1.
      for (int c = 1; c < n_chan; c++) begin
        if (mod_wr_vol[c]) begin
          channel_volume[c] <= data_word[c - 1][6:0];
        end
        if (mod_wr_per[c]) begin
          sample_period[c] <= data_word[c - 1];
        end
      end
      if (wr_en && paddr >= acd_pkg::off_chan_base && addr_ok) begin
        case (paddr[3:0])
          acd_pkg::sub_addr_high:  start_addr_high[reg_chan] <= pwdata[2:0];
          acd_pkg::sub_addr_low:   start_addr_low[reg_chan]  <= pwdata[14:0];
          acd_pkg::sub_word_count: wave_word_count[reg_chan] <= pwdata[15:0];
          acd_pkg::sub_vol_period: begin
            sample_period[reg_chan]  <= pwdata[15:0];
            channel_volume[reg_chan] <= pwdata[22:16];
          end
          default: ;
        endcase
      end
    end
  end

  // Slot strobe comes from outside; two flops, then an edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_s1 <= 1'b0;
      slot_s2 <= 1'b0;
      slot_s3 <= 1'b0;
    end else begin
      slot_s1 <= slot_strobe;
      slot_s2 <= slot_s1;
      slot_s3 <= slot_s2;
    end
  end

  // Round-robin slot pointer gives each channel its own fetch turn.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_idx <= 2'h0;
      busy     <= 1'b0;
      mem_req  <= 1'b0;
      mem_addr <= 18'h00000;
      mem_chan <= 2'h0;
    end else if (busy) begin
      if (mem_ack) begin
        busy    <= 1'b0;
        mem_req <= 1'b0;
      end
    end else if (slot_s2 && !slot_s3) begin
      slot_idx <= slot_idx + 2'h1;
      if (fetch_pend[slot_idx] && chan_on[slot_idx]) begin
        busy     <= 1'b1;
        mem_req  <= 1'b1;
        mem_addr <= work_ptr[slot_idx];
        mem_chan <= slot_idx;
      end
    end
  end

  // Playback engine per channel.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < n_chan; c++) begin
        work_ptr[c]   <= 18'h00000;
        work_len[c]   <= 16'h0000;
        period_cnt[c] <= 16'h0000;
        data_word[c]  <= 16'h0000;
        word_valid[c] <= 1'b0;
        low_half[c]   <= 1'b0;
        running[c]    <= 1'b0;
        mod_is_per[c] <= 1'b0;
        off_cnt[c]    <= 16'h0000;
        fetch_pend[c] <= 1'b0;
        chan_irq[c]   <= 1'b0;
      end
    end else begin
      for (int c = 0; c < n_chan; c++) begin
        chan_irq[c] <= 1'b0;
        if (!chan_on[c]) begin
          // A brief disable keeps the channel alive; longer one stops it.
          if (running[c]) begin
            if (off_cnt[c] >= 16'(sample_period[c] << 1)) begin
              running[c]    <= 1'b0;
              word_valid[c] <= 1'b0;
              fetch_pend[c] <= 1'b0;
            end else begin
              off_cnt[c] <= off_cnt[c] + 16'h0001;
            end
          end
        end else if (!running[c]) begin
          // Start: take working copies and raise the interrupt.
          running[c]    <= 1'b1;
          work_ptr[c]   <= loc_of(start_addr_high[c], start_addr_low[c]);
          work_len[c]   <= wave_word_count[c];
          chan_irq[c]   <= 1'b1;
          fetch_pend[c] <= 1'b1;
          low_half[c]   <= 1'b0;
          mod_is_per[c] <= 1'b0;
          period_cnt[c] <= sample_period[c];
          off_cnt[c]    <= 16'h0000;
        end else begin
          off_cnt[c] <= 16'h0000;
          if (mem_ack && busy && mem_chan == 2'(c)) begin
            data_word[c]  <= mem_rdata;
            word_valid[c] <= 1'b1;
            fetch_pend[c] <= 1'b0;
            if (work_len[c] <= 16'h0001) begin
              // Reload from the live registers, so later writes apply here.
              work_ptr[c] <= loc_of(start_addr_high[c], start_addr_low[c]);
              work_len[c] <= wave_word_count[c];
              chan_irq[c] <= 1'b1;
            end else begin
              work_ptr[c] <= work_ptr[c] + 18'h00001;
              work_len[c] <= work_len[c] - 16'h0001;
            end
          end
          if (period_cnt[c] != 16'h0000) begin
            period_cnt[c] <= period_cnt[c] - 16'h0001;
          end else if (word_valid[c]) begin
            period_cnt[c] <= sample_period[c];
            if (attached[c]) begin
              mod_is_per[c] <= !mod_is_per[c];
              word_valid[c] <= 1'b0;
              fetch_pend[c] <= 1'b1;
            end else begin
              low_half[c] <= !low_half[c];
              if (low_half[c]) begin
                word_valid[c] <= 1'b0;
                fetch_pend[c] <= 1'b1;
              end
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Audio output and read data
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_sample <= 32'h00000000;
      dac_volume <= 28'h0000000;
      dac_active <= 4'h0;
    end else begin
      for (int c = 0; c < n_chan; c++) begin
        dac_active[c] <= running[c] && !attached[c];
        dac_volume[c*7 +: 7] <= channel_volume[c];
        if (expire[c] && !attached[c]) begin
          dac_sample[c*8 +: 8] <= low_half[c] ? data_word[c][7:0]
                                              : data_word[c][15:8];
        end else if (attached[c]) begin
          dac_sample[c*8 +: 8] <= 8'h00;
        end
      end
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (paddr == acd_pkg::off_dma_control) begin
      next_rdata = {16'h0000, dma_control_set_clear};
    end else if (paddr == acd_pkg::off_attach_control) begin
      next_rdata = {24'h000000, attach_control};
    end else if (paddr == acd_pkg::off_status) begin
      for (int c = 0; c < n_chan; c++) begin
        next_rdata[c]     = running[c];
        next_rdata[c + 4] = fetch_pend[c];
      end
    end else if (paddr >= acd_pkg::off_chan_base) begin
      case (paddr[3:0])
        acd_pkg::sub_addr_high:  next_rdata = {29'h0, start_addr_high[reg_chan]};
        acd_pkg::sub_addr_low:   next_rdata = {17'h0, start_addr_low[reg_chan]};
        acd_pkg::sub_word_count: next_rdata = {16'h0, wave_word_count[reg_chan]};
        acd_pkg::sub_vol_period: next_rdata = {9'h0, channel_volume[reg_chan],
                                               sample_period[reg_chan]};
        default:                 next_rdata = 32'h00000000;
      endcase
    end
  end

  // Zero-wait APB: ready is registered during setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite && addr_ok) ? next_rdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_start(int c);
    chan_on[c] && !running[c];
  endsequence

  a_start_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_start(0) |=> chan_irq[0] && running[0])
    else $error("no interrupt after start");
  a_start_copy: assert property (@(posedge pclk) disable iff (!presetn)
    s_start(1) |=> work_len[1] == $past(wave_word_count[1]))
    else $error("length not copied at start");
  // The enable may drop at the very edge that launches a fetch, so the gate is
  // checked against the enables that the slot logic saw at that edge.
  a_fetch_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(mem_req) |-> ($past(chan_on) & (4'h1 << mem_chan)) != 4'h0)
    else $error("fetch while disabled");
  a_set_or_clear_select_op: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == acd_pkg::off_dma_control && pwdata[15] && pwdata[9]
    |=> dma_control_set_clear[9])
    else $error("set did not set");
  a_attach_mute: assert property (@(posedge pclk) disable iff (!presetn)
    attached[2] |=> !dac_active[2])
    else $error("attached channel sounding");
  a_vol_mod: assert property (@(posedge pclk) disable iff (!presetn)
    mod_wr_vol[1] |=> channel_volume[1] == $past(data_word[0][6:0]))
    else $error("volume modulation wrong");
  a_per_mod: assert property (@(posedge pclk) disable iff (!presetn)
    mod_wr_per[1] |=> sample_period[1] == $past(data_word[0]))
    else $error("period modulation wrong");
  a_wrap_reload: assert property (@(posedge pclk) disable iff (!presetn)
    running[0] && chan_on[0] && mem_ack && busy && mem_chan == 2'h0 && work_len[0] <= 16'h0001
    |=> chan_irq[0] && work_ptr[0] == $past(loc_of(start_addr_high[0], start_addr_low[0])))
    else $error("no reload at wrap");

  // ----------------------------------------------------------------------
  // Modulation and timing checks
  // ----------------------------------------------------------------------
  // With both attaches on, one expiry writes exactly one of the two targets.
  a_alt_mod: assert property (@(posedge pclk) disable iff (!presetn)
    chan_on[0] && attach_control[0] && attach_control[acd_pkg::pos_period_attach] &&
    expire[0] |-> (mod_wr_vol[1] != mod_wr_per[1]) ##1 (mod_is_per[0] != $past(mod_is_per[0])))
    else $error("attach modes not alternating");
  // Channel 3 has no target, so its attach bits can only mute it.
  a_ch3_silent: assert property (@(posedge pclk) disable iff (!presetn)
    attach_control[3] |=> !dac_active[3] && dac_sample[31:24] == 8'h00)
    else $error("attached channel 3 sounding");
  a_short_keep: assert property (@(posedge pclk) disable iff (!presetn)
    running[0] && !chan_on[0] && off_cnt[0] < 16'(sample_period[0] << 1) |=> running[0])
    else $error("short disable stopped channel");
  // A running, enabled channel counts a nonzero period down by one on every clock.
  a_period_count: assert property (@(posedge pclk) disable iff (!presetn)
    running[1] && chan_on[1] && period_cnt[1] != 16'h0000
    |=> period_cnt[1] == $past(period_cnt[1]) - 16'h0001)
    else $error("period count not decrementing");
endmodule : acd_player

// file: acd_pkg.sv
// Function
// - Started channel loops its waveform until disabled.
// - Fetch only with master and channel enables.
// - Bit 15 picks set or clear.
// - Re-enable restarts from the location registers.
// - Short disable under two periods may continue.
// - Length counts words before returning to start.
// - Location is three high, fifteen low bits.
// - Start copies length and location to working.
// - Interrupt right after the working copies.
// - Later register writes leave current playback alone.
// - Length reaching zero reloads both, no gap.
// - Fetch words in the channel's own slot.
// - Unattached word carries two 8-bit samples.
// - Attached channel is silent and modulates next.
// - Modulator period expiry writes next word over.
// - Volume word uses bits 6-0 only.
// - Period word uses all sixteen bits.
// - Both attaches alternate, volume first.
// - Modulator and modulated lengths are independent.
// - Either attach bit silences the channel.
// - Channel 0 attaches at bits 0 and 4.
// - Channel 3 attach only silences it.
// - Volume attaches bits 0-3, period bits 4-7.
// - Period counts down clocks; zero takes next sample.
package acd_pkg;
  // ----------------------------------------------------------------------
  // Register map (word aligned byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] off_dma_control    = 8'h00;
  localparam logic [7:0] off_attach_control = 8'h04;
  localparam logic [7:0] off_status         = 8'h08;
  localparam logic [7:0] off_chan_base      = 8'h10;
  localparam logic [7:0] off_chan_stride    = 8'h10;
  localparam logic [3:0] sub_addr_high      = 4'h0;
  localparam logic [3:0] sub_addr_low       = 4'h4;
  localparam logic [3:0] sub_word_count     = 4'h8;
  localparam logic [3:0] sub_vol_period     = 4'hc;
  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          bit_set_or_clear  = 15;
  localparam int          bit_master_enable = 9;
  localparam int          pos_period_attach = 4;
  localparam logic [15:0] dma_control_reset = 16'h0000;
  localparam logic [7:0]  attach_reset      = 8'h00;
  localparam logic [15:0] period_reset      = 16'h0000;
  localparam logic [6:0]  volume_reset      = 7'h00;
  localparam int          addr_high_width   = 3;
  localparam int          addr_low_width    = 15;
endpackage : acd_pkg

// file: acd_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Memory partner for the fetch port
// ----------------------------------------------------------------------
module acd_mem_model (
  input  wire logic        pclk,      // System clock.
  input  wire logic        presetn,   // Reset, active low.
  input  wire logic        slow,      // High for a slow answer.
  input  wire logic        mem_req,   // Fetch request.
  input  wire logic [17:0] mem_addr,  // Word address.
  output logic             mem_ack,   // Data valid pulse.
  output logic      [15:0] mem_rdata  // Fetched word.
);
  logic [2:0] wait_cnt;
  // Idle data flips every cycle so that a stale word is never mistaken for a fresh one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 3'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 3'h0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_cnt >= (slow ? 3'h4 : 3'h0)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= {mem_addr[7:0], ~mem_addr[7:0]};
    end else begin
      wait_cnt  <= wait_cnt + (mem_req ? 3'h1 : 3'h0);
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : acd_mem_model

// file: tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        mem_req, mem_ack, slot_strobe, slow;
  logic [7:0]  paddr, last_b;
  logic [31:0] pwdata, prdata, r, dac_sample;
  logic [17:0] mem_addr;
  logic [1:0]  mem_chan;
  logic [15:0] mem_rdata;
  logic [3:0]  chan_irq, dac_active;
  logic [27:0] dac_volume;
  logic [17:0] fq[$];
  logic [7:0]  bq[$];
  int          fails, num_checks, irq0, cyc, n;
  localparam logic [7:0]  ra[9] = '{8'h04, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h04};
  localparam logic [31:0] rw[9] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
                                    32'hffffffff, 32'h0000820f, 32'h00000205, 32'h0000000a, 32'h0};
  localparam logic [31:0] rx[9] = '{32'h000000ff, 32'h00000007, 32'h00007fff, 32'h0000ffff,
                                    32'h007fffff, 32'h0000020f, 32'h0000000a, 32'h0, 32'h0};
  localparam logic [17:0] fe[5] = '{18'h08010, 18'h08011, 18'h08020, 18'h08021, 18'h08020};
  localparam logic [7:0]  be[4] = '{8'h10, 8'hef, 8'h11, 8'hee};

  acd_player acd_player_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_chan(mem_chan),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .slot_strobe(slot_strobe), .chan_irq(chan_irq),
    .dac_sample(dac_sample), .dac_volume(dac_volume), .dac_active(dac_active));
  acd_mem_model acd_mem_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Fetches and byte changes of channel 0 are logged for later comparison.
  always @(posedge pclk) begin
    cyc++;
    slot_strobe <= (cyc % 8) < 2;
    if (mem_req && mem_ack && mem_chan === 2'd0) fq.push_back(mem_addr);
    if (chan_irq[0] === 1'b1) irq0++;
    if (dac_sample[7:0] !== last_b) bq.push_back(dac_sample[7:0]);
    last_b = dac_sample[7:0];
    if (cyc > 30000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // The request stands until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so that a following call never drives psel twice in one step.
    @(posedge pclk);
  endtask : apb

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask : wt

  task automatic wfq(input int k, input bit bytes);
    n = 0;
    while ((bytes ? bq.size() : fq.size()) < k && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wfq

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial begin
    {psel, penable, pwrite, slow, presetn} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, ra[i], rw[i]);
      apb(1'b0, ra[i], 32'h0);
      chk("reg", rx[i], r);
      chk("reg_err", 32'h0, {31'h0, e});
    end
    apb(1'b1, 8'h0c, 32'h1234);
    chk("unmapped_err", 32'h1, {31'h0, e});
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_data", 32'h0, r);
    // Channel 0 plays two words; its location moves while the first copy plays.
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h14, 32'h10);
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b1, 8'h1c, 32'h00400028);
    fq.delete();
    bq.delete();
    irq0 = 0;
    apb(1'b1, 8'h00, 32'h8201);
    n = 0;
    while (irq0 < 1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("irq_start", 32'h1, {31'h0, irq0 >= 1});
    apb(1'b1, 8'h14, 32'h20);
    wfq(5, 1'b0);
    for (int i = 0; i < 5; i++) chk("fetch_addr", {14'h0, fe[i]}, {14'h0, fq[i]});
    chk("irq_wrap", 32'h1, {31'h0, irq0 >= 2});
    wfq(4, 1'b1);
    for (int i = 0; i < 4; i++) chk("byte_order", {24'h0, be[i]}, {24'h0, bq[i]});
    apb(1'b1, 8'h00, 32'h0200);
    wt(100);
    fq.delete();
    wt(200);
    chk("no_fetch", 32'h0, fq.size());
    apb(1'b1, 8'h00, 32'h0001);
    wt(100);
    fq.delete();
    apb(1'b1, 8'h00, 32'h8201);
    wfq(1, 1'b0);
    chk("restart_addr", 32'h08020, {14'h0, fq[0]});
    // Channel 0 modulates channel 1 from a slow memory; channel 3 is silenced.
    slow <= 1'b1;
    apb(1'b1, 8'h20, 32'h1);
    apb(1'b1, 8'h24, 32'h100);
    apb(1'b1, 8'h28, 32'h4);
    apb(1'b1, 8'h2c, 32'h00010028);
    apb(1'b1, 8'h48, 32'h2);
    apb(1'b1, 8'h4c, 32'h00010028);
    apb(1'b1, 8'h04, 32'h09);
    apb(1'b1, 8'h00, 32'h800b);
    wt(600);
    chk("active0", 32'h0, {31'h0, dac_active[0]});
    chk("active1", 32'h1, {31'h0, dac_active[1]});
    chk("active3", 32'h0, {31'h0, dac_active[3]});
    chk("vol1", 32'h1, {31'h0, dac_volume[13:7] inside {7'h5e, 7'h5f}});
    apb(1'b1, 8'h04, 32'h10);
    wt(600);
    apb(1'b0, 8'h2c, 32'h0);
    chk("per1", 32'h1, {31'h0, r[15:0] inside {16'h20df, 16'h21de}});
    // Both attaches: volume and period must come from the two different words.
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h2c, 32'h00010028);
    apb(1'b1, 8'h04, 32'h11);
    wt(600);
    apb(1'b0, 8'h2c, 32'h0);
    chk("both1", 32'h1, {31'h0, r[22:0] inside {23'h5f21de, 23'h5e20df}});
    presetn <= 1'b0;
    wt(2);
    chk("rst_out", 32'h0, {27'h0, mem_req, dac_active});
    presetn <= 1'b1;
    wt(1);
    apb(1'b0, 8'h00, 32'h0);
    chk("rst_dma", 32'h0, r);
    apb(1'b0, 8'h04, 32'h0);
    chk("rst_attach", 32'h0, r);
    stop_test();
  end
endmodule : tb
